/* inc/ppf_pkg.sv */
// constants, types and timing table for the printer port block
package ppf_pkg;
   // host register addresses
   localparam logic [1:0] ADR_DATA = 2'h0;
   localparam logic [1:0] ADR_STATUS = 2'h1;
   localparam logic [1:0] ADR_PINS = 2'h2;
   localparam logic [1:0] ADR_AFR = 2'h3;
   // pin control field positions
   localparam int CON_STROBE = 0;
   localparam int CON_AUTOFD = 1;
   localparam int CON_INIT = 2;
   localparam int CON_SELIN = 3;
   localparam int CON_INTEN = 4;
   localparam int CON_DIR = 5;
   // alternate function field positions
   localparam int AFR_TSEL_LO = 0;
   localparam int AFR_HS_SRC = 3;
   localparam int AFR_TYPE_LO = 4;
   localparam int AFR_POL = 6;
   localparam int AFR_FIFO_EN = 7;
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] AFR_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   // interrupt type codes
   localparam logic [1:0] ITYPE_NORMAL = 2'h0;
   localparam logic [1:0] ITYPE_EMPTY = 2'h1;
   localparam logic [1:0] ITYPE_FULL = 2'h2;
   localparam logic [1:0] ITYPE_EMPTY_ALT = 2'h3;
   // pin readback bits that are always one
   localparam logic [2:0] COM_UNUSED = 3'h7;
   // fifo shape
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 83;
   localparam int FIFO_CW = 7;
   localparam int TCNT_W = 5;

   // automatic strobe sequencer states
   typedef enum logic [1:0] {
      STB_IDLE = 2'b00,
      STB_DELAY = 2'b01,
      STB_PULSE = 2'b10,
      STB_WAIT = 2'b11
   } ppf_stb_t;

   // strobe delay in clocks from the timing select field
   function automatic logic [TCNT_W-1:0] ppf_tsd(input logic [2:0] sel);
      unique case (sel)
         3'h4: ppf_tsd = 5'h03;
         3'h5, 3'h6: ppf_tsd = 5'h05;
         3'h7: ppf_tsd = 5'h09;
         3'h0: ppf_tsd = 5'h06;
         3'h1, 3'h2: ppf_tsd = 5'h0A;
         3'h3: ppf_tsd = 5'h12;
      endcase
   endfunction : ppf_tsd

   // strobe width in clocks from the timing select field
   function automatic logic [TCNT_W-1:0] ppf_tsw(input logic [2:0] sel);
      unique case (sel)
         3'h4: ppf_tsw = 5'h02;
         3'h5, 3'h6, 3'h0: ppf_tsw = 5'h04;
         3'h7, 3'h1, 3'h2: ppf_tsw = 5'h08;
         3'h3: ppf_tsw = 5'h10;
      endcase
   endfunction : ppf_tsw
endpackage : ppf_pkg

/* inc/ppf_stream_if.sv */
// fill and drain signals between the port logic and its output fifo
interface ppf_stream_if;
   import ppf_pkg::*;
   logic push_valid;
   logic push_ready;
   logic [DATA_W-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [DATA_W-1:0] pop_data;
   logic [FIFO_CW-1:0] count;
   logic flush;

   modport port (
      output push_valid, push_data, pop_ready, flush,
      input push_ready, pop_valid, pop_data, count
   );
   modport fifo (
      input push_valid, push_data, pop_ready, flush,
      output push_ready, pop_valid, pop_data, count
   );
endinterface : ppf_stream_if

/* hw/ppf_fifo.sv */
// byte fifo with occupancy count between host writes and printer data lines
module ppf_fifo
   import ppf_pkg::*;
#(
   parameter int WIDTH = DATA_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // fill and drain side
   ppf_stream_if.fifo st
);
   typedef struct packed {
      logic [FIFO_CW-1:0] wptr;
      logic [FIFO_CW-1:0] rptr;
      logic [FIFO_CW-1:0] count;
   } ppf_fifo_state_t;

   localparam logic [FIFO_CW-1:0] LAST = FIFO_CW'(DEPTH - 1);
   localparam logic [FIFO_CW-1:0] FULL_CNT = FIFO_CW'(DEPTH);

   ppf_fifo_state_t st_reg, st_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic do_push, do_pop;

   // honest flags toward both sides
   assign st.push_ready = (st_reg.count != FULL_CNT);
   assign st.pop_valid = (st_reg.count != '0);
   assign st.pop_data = mem[st_reg.rptr];
   assign st.count = st_reg.count;
   assign do_push = st.push_valid && st.push_ready;
   assign do_pop = st.pop_ready && st.pop_valid;

   // pointer and count update, flush clears all
   always_comb begin
      st_next = st_reg;
      if (st.flush) begin
         st_next = '0;
      end else begin
         if (do_push) begin
            st_next.wptr = (st_reg.wptr == LAST) ? '0 : st_reg.wptr + 1'b1;
         end
         if (do_pop) begin
            st_next.rptr = (st_reg.rptr == LAST) ? '0 : st_reg.rptr + 1'b1;
         end
         // up per write, down per printer take
         if (do_push && !do_pop) begin
            st_next.count = st_reg.count + 1'b1; // RL10
         end else if (do_pop && !do_push) begin
            st_next.count = st_reg.count - 1'b1; // RL10
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // storage write, full fifo drops the byte
   always_ff @(posedge sys_clk) begin
      if (do_push && !st.flush) begin // RL11
         mem[st_reg.wptr] <= st.push_data;
      end
   end
endmodule : ppf_fifo

/* hw/ppf_top.sv */
// parallel printer port: host registers, pin control, output fifo and interrupt
// What this block does
// RL1: handshake source bit picks accept pulse when 0, busy when 1.
// RL2: interrupt type bits choose normal, fifo empty or fifo full; status bit0 low for 11.
// RL3: reset leaves data lines output, strobe, feed, select-in high, printer reset low.
// RL4: polarity bit 0 keeps interrupt sense, 1 inverts it.
// RL5: fifo enable resets to 0; writing 1 puts the 83 byte fifo in path.
// RL6: byte count bits 6:0 give bytes left in fifo, bit0 least significant.
// RL7: byte count bit7 reads 0 when fifo enabled, 1 when disabled.
// RL8: host watches fifo fill and state by reading the byte count register.
// RL9: address 2 reads pin state, writes pin control; address 3 likewise alternate/count.
// RL10: counter goes up per data write, down per byte taken by printer.
// RL11: data write into a full fifo is dropped and not counted.
// RL12: one byte leaves the fifo on the falling edge of the chosen handshake.
// RL13: timing select sets strobe delay and width from the eight entry table.
module ppf_top
   import ppf_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // host register port
   input wire logic cs_n,
   input wire logic ior_n,
   input wire logic iow_n,
   input wire logic [1:0] addr,
   input wire logic [7:0] d_in,
   output logic [7:0] d_out,
   output logic d_oe,
   // printer data lines
   input wire logic [7:0] printer_data_lines_in,
   output logic [7:0] printer_data_lines_out,
   output logic printer_data_lines_oe,
   // printer control outputs
   output logic strobe_n,
   output logic auto_feed_n,
   output logic printer_reset_n,
   output logic select_in_n,
   // printer status inputs
   input wire logic accept_n,
   input wire logic busy,
   input wire logic error_n,
   input wire logic printer_selected,
   input wire logic media_out,
   input wire logic int_latch_sel,
   // interrupt output
   output logic int_out,
   output logic int_oe
);
   typedef struct packed {
      logic [2:0] s1_ctl;
      logic [2:0] s2_ctl;
      logic [1:0] s1_adr;
      logic [1:0] s2_adr;
      logic [7:0] s1_dat;
      logic [7:0] s2_dat;
      logic [7:0] s1_pd;
      logic [7:0] s2_pd;
      logic [5:0] s1_pin;
      logic [5:0] s2_pin;
      logic wr_prev;
      logic rd_prev;
      logic hs_prev;
      logic [7:0] data;
      logic [7:0] ctrl;
      logic [7:0] alternate_function;
      logic latched_n;
      logic plain_n;
      ppf_stb_t stb;
      logic [TCNT_W-1:0] cnt;
      logic [7:0] d_out;
      logic d_oe;
      logic [7:0] pd_out;
      logic pd_oe;
      logic strobe_n;
      logic auto_feed_n;
      logic printer_reset_n;
      logic select_in_n;
      logic int_out;
      logic int_oe;
   } ppf_state_t;

   localparam ppf_state_t ST_RST = '{
      s1_ctl: 3'h7, s2_ctl: 3'h7, s1_adr: 2'h0, s2_adr: 2'h0,
      s1_dat: 8'h00, s2_dat: 8'h00, s1_pd: 8'h00, s2_pd: 8'h00,
      s1_pin: 6'h3F, s2_pin: 6'h3F, wr_prev: 1'b0, rd_prev: 1'b0, hs_prev: 1'b1,
      data: DATA_RST, ctrl: CTRL_RST, alternate_function: AFR_RST, latched_n: 1'b1, plain_n: 1'b1,
      stb: STB_IDLE, cnt: 5'h00, d_out: 8'h00, d_oe: 1'b0, pd_out: 8'h00,
      pd_oe: 1'b1, strobe_n: 1'b1, auto_feed_n: 1'b1, printer_reset_n: 1'b0,
      select_in_n: 1'b1, int_out: 1'b1, int_oe: 1'b0};

   ppf_state_t st_reg, st_next;
   ppf_stream_if fq ();

   logic wr_act, rd_act, wr_rise, rd_rise, hs_now, hs_fall, fifo_on;
   logic [1:0] itype;
   logic int_level;

   ppf_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .reset(reset),
      .st(fq.fifo)
   );

   // decoded host strobes and handshake edge, all from synchronised pins
   assign wr_act = !st_reg.s2_ctl[2] && !st_reg.s2_ctl[0];
   assign rd_act = !st_reg.s2_ctl[2] && !st_reg.s2_ctl[1];
   assign wr_rise = wr_act && !st_reg.wr_prev;
   assign rd_rise = rd_act && !st_reg.rd_prev;
   assign hs_now = st_reg.alternate_function[AFR_HS_SRC] ? st_reg.s2_pin[4] : st_reg.s2_pin[5]; // RL1
   assign hs_fall = st_reg.hs_prev && !hs_now;
   assign fifo_on = st_reg.alternate_function[AFR_FIFO_EN]; // RL5
   assign itype = st_reg.alternate_function[AFR_TYPE_LO +: 2];

   // fifo hookup: host data writes fill, handshake falling edge drains
   assign fq.push_valid = fifo_on && wr_rise && (st_reg.s2_adr == ADR_DATA); // RL11
   assign fq.push_data = st_reg.s2_dat;
   assign fq.pop_ready = fifo_on && hs_fall && (st_reg.stb == STB_WAIT); // RL12
   assign fq.flush = !fifo_on || (st_reg.ctrl[CON_INIT] == 1'b0);

   // interrupt source choice ahead of polarity
   always_comb begin
      unique case (itype)
         ITYPE_NORMAL: int_level = st_reg.s2_pin[0] ? st_reg.plain_n : st_reg.latched_n; // RL2
         ITYPE_EMPTY, ITYPE_EMPTY_ALT: int_level = !fq.pop_valid; // RL2
         ITYPE_FULL: int_level = !fq.push_ready; // RL2
      endcase
   end

   // next state of the whole port
   always_comb begin
      st_next = st_reg;
      st_next.s1_ctl = {cs_n, ior_n, iow_n};
      st_next.s2_ctl = st_reg.s1_ctl;
      st_next.s1_adr = addr;
      st_next.s2_adr = st_reg.s1_adr;
      st_next.s1_dat = d_in;
      st_next.s2_dat = st_reg.s1_dat;
      st_next.s1_pd = printer_data_lines_in;
      st_next.s2_pd = st_reg.s1_pd;
      // strap goes through the same two flops as the status pins
      st_next.s1_pin = {accept_n, busy, error_n, printer_selected, media_out, int_latch_sel};
      st_next.s2_pin = st_reg.s1_pin;
      st_next.wr_prev = wr_act;
      st_next.rd_prev = rd_act;
      st_next.hs_prev = hs_now;
      // host writes
      if (wr_rise) begin
         unique case (st_reg.s2_adr)
            ADR_DATA: begin
               st_next.data = st_reg.s2_dat;
               st_next.plain_n = 1'b1;
            end
            ADR_STATUS: ;
            ADR_PINS: begin
               st_next.ctrl = st_reg.s2_dat; // RL9
               if (st_reg.s2_dat[CON_STROBE]) begin
                  st_next.plain_n = 1'b0;
               end
            end
            ADR_AFR: begin
               st_next.alternate_function = st_reg.s2_dat; // RL9
               // track the newly chosen pin so a source swap is no false edge
               st_next.hs_prev = st_reg.s2_dat[AFR_HS_SRC] ?
                  st_reg.s2_pin[4] : st_reg.s2_pin[5]; // RL1
            end
         endcase
      end
      // status read releases the latched flag, handshake edge wins
      if (rd_rise && st_reg.s2_adr == ADR_STATUS) begin
         st_next.latched_n = 1'b1;
      end
      if (hs_fall) begin
         st_next.latched_n = 1'b0;
      end
      // automatic strobe: delay, pulse, then wait for the printer to take it
      unique case (st_reg.stb)
         STB_IDLE: begin
            if (fifo_on && fq.pop_valid) begin
               st_next.stb = STB_DELAY;
               st_next.cnt = ppf_tsd(st_reg.alternate_function[AFR_TSEL_LO +: 3]) - 1'b1; // RL13
            end
         end
         STB_DELAY: begin
            st_next.cnt = st_reg.cnt - 1'b1;
            if (st_reg.cnt == '0) begin
               st_next.stb = STB_PULSE;
               st_next.cnt = ppf_tsw(st_reg.alternate_function[AFR_TSEL_LO +: 3]) - 1'b1; // RL13
            end
         end
         STB_PULSE: begin
            st_next.cnt = st_reg.cnt - 1'b1;
            if (st_reg.cnt == '0) begin
               st_next.stb = STB_WAIT;
            end
         end
         STB_WAIT: begin
            if (hs_fall || !fifo_on) begin
               st_next.stb = STB_IDLE;
            end
         end
      endcase
      // host read data
      st_next.d_oe = rd_act;
      unique case (st_reg.s2_adr)
         ADR_DATA: st_next.d_out = st_reg.ctrl[CON_DIR] ? st_reg.s2_pd : st_reg.data;
         ADR_STATUS: st_next.d_out = {fifo_on ? fq.push_ready : !st_reg.s2_pin[4],
            st_reg.plain_n, st_reg.s2_pin[1], st_reg.s2_pin[2], st_reg.s2_pin[3],
            st_reg.latched_n, {2{itype != ITYPE_EMPTY_ALT}}}; // RL2
         ADR_PINS: st_next.d_out = {COM_UNUSED, st_reg.ctrl[CON_INTEN],
            !st_reg.select_in_n, st_reg.printer_reset_n,
            !st_reg.auto_feed_n, !st_reg.strobe_n}; // RL9
         ADR_AFR: st_next.d_out = {!fifo_on, fq.count}; // RL6 RL7 RL8
      endcase
      // printer pins
      st_next.pd_oe = !st_reg.ctrl[CON_DIR];
      st_next.pd_out = fifo_on ? fq.pop_data : st_reg.data;
      st_next.strobe_n = fifo_on ? (st_reg.stb != STB_PULSE) : !st_reg.ctrl[CON_STROBE];
      st_next.auto_feed_n = !st_reg.ctrl[CON_AUTOFD];
      st_next.printer_reset_n = st_reg.ctrl[CON_INIT];
      st_next.select_in_n = !st_reg.ctrl[CON_SELIN];
      st_next.int_out = int_level ^ st_reg.alternate_function[AFR_POL]; // RL4
      st_next.int_oe = st_reg.ctrl[CON_INTEN];
   end

   // one register for the whole port, reset per printer idle state
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         st_reg <= ST_RST; // RL3
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from flops
   assign d_out = st_reg.d_out;
   assign d_oe = st_reg.d_oe;
   assign printer_data_lines_out = st_reg.pd_out;
   assign printer_data_lines_oe = st_reg.pd_oe;
   assign strobe_n = st_reg.strobe_n;
   assign auto_feed_n = st_reg.auto_feed_n;
   assign printer_reset_n = st_reg.printer_reset_n;
   assign select_in_n = st_reg.select_in_n;
   assign int_out = st_reg.int_out;
   assign int_oe = st_reg.int_oe;
endmodule : ppf_top

/* sim/ppf_checker.sv */
// assertions on the host strobes and printer pins of the port
module ppf_checker (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // host side
   input wire logic cs_n,
   input wire logic ior_n,
   input wire logic iow_n,
   input wire logic d_oe,
   // printer side
   input wire logic [7:0] printer_data_lines_out,
   input wire logic printer_data_lines_oe,
   input wire logic strobe_n,
   input wire logic auto_feed_n,
   input wire logic printer_reset_n,
   input wire logic select_in_n,
   input wire logic accept_n,
   input wire logic busy,
   input wire logic int_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // pin levels right after reset release
   property p_rst;
      $fell(reset) |-> strobe_n && auto_feed_n && select_in_n && !printer_reset_n;
   endproperty
   a_rst: assert property (p_rst) else $error("reset pin levels");
   property p_rst_dir;
      $fell(reset) |-> printer_data_lines_oe && !int_oe && !d_oe;
   endproperty
   a_rst_dir: assert property (p_rst_dir) else $error("reset directions");
   // host read answers and release
   property p_rd_ans;
      $rose(!cs_n && !ior_n) |-> ##[2:5] d_oe;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   property p_rd_hold;
      (!cs_n && !ior_n)[*5] |-> d_oe;
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped");
   property p_rd_end;
      $rose(cs_n || ior_n) |-> ##[2:5] !d_oe;
   endproperty
   a_rd_end: assert property (p_rd_end) else $error("bus not released");
   property p_idle;
      (cs_n || ior_n)[*6] |-> !d_oe;
   endproperty
   a_idle: assert property (p_idle) else $error("bus driven when idle");
   property p_wr_quiet;
      (!cs_n && !iow_n)[*5] |-> !d_oe;
   endproperty
   a_wr_quiet: assert property (p_wr_quiet) else $error("bus driven on write");
   // control pins other than strobe_n move only on host writes
   property p_pins_hold;
      iow_n[*8] |-> $stable({auto_feed_n, select_in_n, printer_reset_n, int_oe,
         printer_data_lines_oe});
   endproperty
   a_pins_hold: assert property (p_pins_hold) else $error("pin moved unasked");
   // data lines move only on writes or a handshake edge
   property p_pd_hold;
      (iow_n && accept_n && !busy)[*8] |-> $stable(printer_data_lines_out);
   endproperty
   a_pd_hold: assert property (p_pd_hold) else $error("data moved unasked");
endmodule : ppf_checker

/* sim/ppf_printer_model.sv */
// behavioural printer: takes a byte on strobe, answers with busy and accept
module ppf_printer_model (
   // clock
   input wire logic sys_clk,
   // cable from the port
   input wire logic strobe_n,
   input wire logic [7:0] pd,
   // scenario controls
   input wire logic stall,
   input wire logic ack_only,
   // cable to the port
   output logic accept_n,
   output logic busy,
   output logic [7:0] pd_drive,
   output logic [7:0] got,
   output int rx
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   logic stb_q = 1'b1;
   // latch on strobe fall, count down the answer unless stalled
   always @(posedge sys_clk) begin
      stb_q <= strobe_n;
      if (stb_q && !strobe_n) begin
         got <= pd;
         rx <= rx + 1;
         cnt <= 8;
      end else if (cnt != 0 && !stall) begin
         cnt <= cnt - 1;
      end
   end
   // accept pulse of four clocks, busy falls inside it
   assign accept_n = !(cnt inside {[1:4]});
   assign busy = !ack_only && cnt > 2;
   assign pd_drive = 8'h5A;
   initial rx = 0;
endmodule : ppf_printer_model

/* sim/tb_top.sv */
// testbench for the printer port block
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin errors++; \
   $display("unexpected %0t %s", $time, m); end end
module tb_top
   import ppf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0, reset, cs_n, ior_n, iow_n, d_oe, pd_oe, strobe_n, auto_feed_n;
   logic printer_reset_n, select_in_n, accept_n, busy, error_n, printer_selected;
   logic media_out, int_out, int_oe, stall, ack_only;
   logic [1:0] addr;
   logic [7:0] d_in, d_out, pd_in, pd_out, pd_drive, got;
   int rx, errors = 0, cmp_count = 0, low_n = 0, strobe_w = 0;
   always #10 sys_clk = ~sys_clk;
   assign pd_in = pd_oe ? pd_out : pd_drive;
   ppf_top ppf_top_i (.sys_clk(sys_clk), .reset(reset), .cs_n(cs_n), .ior_n(ior_n),
      .iow_n(iow_n), .addr(addr), .d_in(d_in), .d_out(d_out), .d_oe(d_oe),
      .printer_data_lines_in(pd_in), .printer_data_lines_out(pd_out),
      .printer_data_lines_oe(pd_oe), .strobe_n(strobe_n), .auto_feed_n(auto_feed_n),
      .printer_reset_n(printer_reset_n), .select_in_n(select_in_n), .accept_n(accept_n),
      .busy(busy), .error_n(error_n), .printer_selected(printer_selected),
      .media_out(media_out), .int_latch_sel(1'b0), .int_out(int_out), .int_oe(int_oe));
   ppf_printer_model ppf_printer_model_i (.sys_clk(sys_clk), .strobe_n(strobe_n),
      .pd(pd_in), .stall(stall), .ack_only(ack_only), .accept_n(accept_n), .busy(busy),
      .pd_drive(pd_drive), .got(got), .rx(rx));
   // width of the last low pulse on strobe_n
   always @(posedge sys_clk) begin
      if (!strobe_n) begin
         low_n++;
      end else if (low_n != 0) begin
         strobe_w = low_n;
         low_n = 0;
      end
   end
   // host write strobe of five clocks
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      d_in <= d;
      @(posedge sys_clk);
      cs_n <= 1'b0;
      iow_n <= 1'b0;
      repeat (5) @(posedge sys_clk);
      cs_n <= 1'b1;
      iow_n <= 1'b1;
      repeat (5) @(posedge sys_clk);
   endtask : wr
   // host read, data taken while the answer stands
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      addr <= a;
      @(posedge sys_clk);
      cs_n <= 1'b0;
      ior_n <= 1'b0;
      do @(negedge sys_clk); while (d_oe !== 1'b1 && n++ < 20);
      repeat (2) @(negedge sys_clk);
      d = d_out;
      `CHK(d_oe, 1'b1, "read answer")
      @(posedge sys_clk);
      cs_n <= 1'b1;
      ior_n <= 1'b1;
      repeat (5) @(posedge sys_clk);
   endtask : rd
   task automatic t_reset;
      logic [7:0] v;
      `CHK({strobe_n, auto_feed_n, select_in_n, printer_reset_n, pd_oe}, 5'h1D, "rst")
      rd(ADR_AFR, v);
      `CHK(v, 8'h80, "count at reset")
      rd(ADR_PINS, v);
      `CHK(v, 8'hE0, "pins at reset")
      error_n <= 1'b0;
      media_out <= 1'b1;
      rd(ADR_STATUS, v);
      `CHK(v & 8'hBB, 8'hB3, "status")
      error_n <= 1'b1;
      media_out <= 1'b0;
   endtask : t_reset
   task automatic t_pins;
      logic [7:0] v;
      wr(ADR_PINS, 8'h1E);
      `CHK({auto_feed_n, printer_reset_n, select_in_n, int_oe}, 4'h5, "pin ctl")
      rd(ADR_PINS, v);
      `CHK(v, 8'hFE, "pin readback")
      wr(ADR_PINS, 8'h04);
      rd(ADR_PINS, v);
      `CHK(v, 8'hE4, "pin readback 2")
      // input mode: data read returns the printer side pins
      wr(ADR_PINS, 8'h24);
      rd(ADR_DATA, v);
      `CHK({pd_oe, v}, 9'h05A, "input mode read")
      wr(ADR_PINS, 8'h04);
   endtask : t_pins
   task automatic t_fill;
      logic [7:0] v;
      stall <= 1'b1;
      wr(ADR_AFR, 8'hA0);
      for (int i = 0; i < FIFO_DEPTH; i++) wr(ADR_DATA, 8'(i));
      wr(ADR_DATA, 8'hFF);
      rd(ADR_AFR, v);
      `CHK(v, 8'h53, "full count")
      rd(ADR_STATUS, v);
      `CHK(v & 8'h83, 8'h03, "full status")
      `CHK(int_out, 1'b1, "full int")
      wr(ADR_AFR, 8'hE0);
      `CHK(int_out, 1'b0, "inverted int")
      stall <= 1'b0;
      wr(ADR_AFR, 8'hB0);
      // the dropped byte never reaches the printer
      for (int n = 0; n < 5000 && rx < FIFO_DEPTH; n++) @(posedge sys_clk);
      repeat (30) @(posedge sys_clk);
      `CHK(rx, FIFO_DEPTH, "bytes out")
      `CHK(got, 8'h52, "last byte")
      rd(ADR_AFR, v);
      `CHK(v, 8'h00, "drained count")
      rd(ADR_STATUS, v);
      `CHK({v[1:0], int_out}, 3'h1, "empty alt")
      wr(ADR_AFR, 8'h90);
      rd(ADR_STATUS, v);
      `CHK({v[1:0], int_out}, 3'h7, "empty")
   endtask : t_fill
   task automatic t_busy;
      logic [7:0] v;
      ack_only <= 1'b1;
      wr(ADR_AFR, 8'h8B);
      wr(ADR_DATA, 8'h11);
      wr(ADR_DATA, 8'h22);
      repeat (100) @(posedge sys_clk);
      rd(ADR_AFR, v);
      `CHK(v, 8'h02, "accept ignored")
      `CHK(strobe_w, 16, "width 16")
      wr(ADR_AFR, 8'h00);
      rd(ADR_AFR, v);
      `CHK(v, 8'h80, "disabled")
      ack_only <= 1'b0;
      wr(ADR_AFR, 8'h8C);
      wr(ADR_DATA, 8'h33);
      wr(ADR_DATA, 8'h44);
      repeat (150) @(posedge sys_clk);
      rd(ADR_AFR, v);
      `CHK(v, 8'h00, "busy pops")
      `CHK(strobe_w, 2, "width 2")
   endtask : t_busy
   // normal interrupt type: accept edge latches, status read clears
   task automatic t_intr;
      logic [7:0] v;
      wr(ADR_AFR, 8'h00);
      rd(ADR_STATUS, v);
      `CHK(int_out, 1'b1, "int idle")
      wr(ADR_PINS, 8'h05);
      repeat (10) @(posedge sys_clk);
      `CHK(int_out, 1'b0, "accept int")
      wr(ADR_PINS, 8'h04);
      wr(ADR_AFR, 8'h40);
      `CHK(int_out, 1'b1, "inverted normal")
      rd(ADR_STATUS, v);
      `CHK(int_out, 1'b0, "inverted cleared")
   endtask : t_intr
   task automatic results;
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results
   // main sequence
   initial begin
      {cs_n, ior_n, iow_n, error_n, printer_selected} = 5'h1F;
      {media_out, stall, ack_only, reset} = 4'h1;
      addr = 2'h0;
      d_in = 8'h00;
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      t_reset();
      t_pins();
      t_fill();
      t_busy();
      t_intr();
      results();
   end
   // watchdog against a hung handshake
   initial begin
      #300000;
      errors++;
      results();
   end
endmodule : tb_top
bind ppf_top ppf_checker ppf_checker_i (.sys_clk(sys_clk), .reset(reset), .cs_n(cs_n),
   .ior_n(ior_n), .iow_n(iow_n), .d_oe(d_oe), .printer_data_lines_out(printer_data_lines_out),
   .printer_data_lines_oe(printer_data_lines_oe), .strobe_n(strobe_n),
   .auto_feed_n(auto_feed_n), .printer_reset_n(printer_reset_n), .select_in_n(select_in_n),
   .accept_n(accept_n), .busy(busy), .int_oe(int_oe));
